// File: core/i2c_switch_pkg.sv
// shared constants and types for the i2c switch front end
package i2c_switch_pkg;
    localparam int CLK_PERIOD_NS = 4;
    localparam int SDA_HOLD_NS = 300;
    localparam int SDA_HOLD_CYC = (SDA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int IRQ_ASSERT_MAX_US = 4;
    localparam int IRQ_RELEASE_MAX_US = 2;
    localparam int IRQ_REJ_L_NS = 1000;
    localparam int IRQ_REJ_H_NS = 500;
    localparam int IRQ_REJ_L_CYC = (IRQ_REJ_L_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int IRQ_REJ_H_CYC = (IRQ_REJ_H_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int IRQ_ASSERT_MAX_CYC = IRQ_ASSERT_MAX_US * 1000 / CLK_PERIOD_NS;
    localparam int IRQ_RELEASE_MAX_CYC = IRQ_RELEASE_MAX_US * 1000 / CLK_PERIOD_NS;

    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_CONFIG = 4'h8;
    localparam int CFG_EN_BIT = 8;
    localparam logic [4:0] CFG_BASE_RST = 5'h0e;
    localparam logic CFG_EN_RST = 1'b1;
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [1:0] CHAN_RST = 2'h0;
    localparam int CTRL_CHAN0_BIT = 0;
    localparam int CTRL_CHAN1_BIT = 1;
    localparam int CTRL_IRQ0_BIT = 4;
    localparam int CTRL_IRQ1_BIT = 5;
    localparam logic RW_READ = 1'b1;
    localparam logic RW_WRITE = 1'b0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ADDR_ACK = 3'b010,
        ST_WR_DATA = 3'b011,
        ST_WR_ACK = 3'b100,
        ST_RD_DATA = 3'b101,
        ST_RD_ACK = 3'b110,
        ST_WAIT_STOP = 3'b111
    } bus_state_t;

    typedef struct packed {
        logic scl;
        logic sda;
        logic addr_select_hi;
        logic addr_select_lo;
        logic [1:0] channel_irq_input;
    } pins_t;
endpackage

// File: core/pin_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module pin_sync #(
    parameter int WIDTH = 6,
    parameter logic [WIDTH-1:0] RST_VAL = '1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= RST_VAL;
            s2_reg <= RST_VAL;
            s3_reg <= RST_VAL;
        end else begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // a bit only moves once stages two and three agree
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    q[i] <= RST_VAL[i];
                end else if (s2_reg[i] == s3_reg[i]) begin
                    q[i] <= s3_reg[i];
                end
            end
        end
    endgenerate
endmodule

// File: core/i2c_switch_slave_front_end.sv
// i2c slave front end of a two-channel bus switch with avalon-mm status port
// Behaviour
// - address lsb one reads, zero writes
// - combined interrupt asserts within 4 us
// - combined interrupt releases within 2 us
// - sda held 300 ns after scl falls
// - ack driven within 1 us of scl low
// - start recognised immediately after reset release
// - each written byte lands in control register
// - bits 0,1 enable channels, applied at stop
// - bits 4,5 read interrupt inputs, writes ignored
// - reset clears control register, sets config to base 0x0e enabled, fsm idle, channels off
//
// Chosen here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module i2c_switch_slave_front_end (
    input wire logic CORE_CLK,
    input wire logic RSTN,
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE,
    input wire logic ADDR_SELECT_LO,
    input wire logic ADDR_SELECT_HI,
    input wire logic [1:0] CHANNEL_IRQ_INPUT,
    output logic IRQ_O,
    output logic IRQ_OE,
    output logic [1:0] CHAN_ACTIVE,
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST
);
    i2c_switch_pkg::pins_t pins_raw;
    i2c_switch_pkg::pins_t pins;
    i2c_switch_pkg::bus_state_t state_reg;
    logic scl_prev_reg;
    logic sda_prev_reg;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic [7:0] shift_reg;
    logic [7:0] tx_reg;
    logic [2:0] cnt_reg;
    logic full_reg;
    logic nack_reg;
    logic [3:0] ctrl_reg;
    logic [1:0] chan_reg;
    logic pend_low_reg;
    logic sda_oe_reg;
    logic [6:0] hold_cnt_reg;
    logic irq_any;
    logic irq_out_reg;
    logic [9:0] irq_cnt_reg;
    logic [4:0] cfg_base_reg;
    logic cfg_en_reg;
    logic wait_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rd_mux;
    logic addr_match;
    logic [7:0] rd_byte;

    assign pins_raw = '{scl: SCL_I, sda: SDA_I, addr_select_hi: ADDR_SELECT_HI,
                        addr_select_lo: ADDR_SELECT_LO, channel_irq_input: CHANNEL_IRQ_INPUT};

    // bus lines and straps idle high; straps must be driven by the board
    pin_sync #(.WIDTH(6), .RST_VAL(6'h3f)) u_sync (
        .clk(CORE_CLK),
        .rst_n(RSTN),
        .d(pins_raw),
        .q(pins)
    );

    assign scl_rise = pins.scl && !scl_prev_reg;
    assign scl_fall = !pins.scl && scl_prev_reg;
    // sda edges while scl stays high mark start and stop
    assign start_det = pins.scl && scl_prev_reg && sda_prev_reg && !pins.sda;
    assign stop_det = pins.scl && scl_prev_reg && !sda_prev_reg && pins.sda;
    // address byte follows start; lsb is direction
    assign addr_match = cfg_en_reg &&
        (shift_reg[7:1] == {cfg_base_reg, pins.addr_select_hi, pins.addr_select_lo});
    // status bits show interrupt inputs, active when low
    assign rd_byte = {2'b00, ~pins.channel_irq_input[1], ~pins.channel_irq_input[0], ctrl_reg};

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_prev_reg <= pins.scl;
            sda_prev_reg <= pins.sda;
        end
    end

    // protocol engine; no recovery delay after reset release
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_reg <= i2c_switch_pkg::ST_IDLE;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            cnt_reg <= 3'h0;
            full_reg <= 1'b0;
            nack_reg <= 1'b0;
            ctrl_reg <= i2c_switch_pkg::CTRL_RST;
            pend_low_reg <= 1'b0;
        end else if (start_det) begin
            state_reg <= i2c_switch_pkg::ST_ADDR;
            cnt_reg <= 3'h0;
            full_reg <= 1'b0;
            pend_low_reg <= 1'b0;
        end else if (stop_det) begin
            state_reg <= i2c_switch_pkg::ST_IDLE;
            pend_low_reg <= 1'b0;
        end else if (scl_rise) begin
            case (state_reg)
                i2c_switch_pkg::ST_ADDR, i2c_switch_pkg::ST_WR_DATA, i2c_switch_pkg::ST_RD_DATA: begin
                    shift_reg <= {shift_reg[6:0], pins.sda};
                    cnt_reg <= cnt_reg + 3'h1;
                    full_reg <= (cnt_reg == 3'h7);
                end
                i2c_switch_pkg::ST_RD_ACK: begin
                    nack_reg <= pins.sda;
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (state_reg)
                i2c_switch_pkg::ST_ADDR: begin
                    if (full_reg) begin
                        full_reg <= 1'b0;
                        if (addr_match) begin
                            state_reg <= i2c_switch_pkg::ST_ADDR_ACK;
                            pend_low_reg <= 1'b1;
                        end else begin
                            state_reg <= i2c_switch_pkg::ST_WAIT_STOP;
                        end
                    end
                end
                i2c_switch_pkg::ST_ADDR_ACK: begin
                    if (shift_reg[0] == i2c_switch_pkg::RW_READ) begin
                        state_reg <= i2c_switch_pkg::ST_RD_DATA;
                        tx_reg <= rd_byte;
                        pend_low_reg <= !rd_byte[7];
                    end else begin
                        state_reg <= i2c_switch_pkg::ST_WR_DATA;
                        pend_low_reg <= 1'b0;
                    end
                end
                i2c_switch_pkg::ST_WR_DATA: begin
                    if (full_reg) begin
                        full_reg <= 1'b0;
                        // every byte overwrites; the last one stays
                        // interrupt bits and the top two are not stored
                        ctrl_reg <= shift_reg[3:0];
                        state_reg <= i2c_switch_pkg::ST_WR_ACK;
                        pend_low_reg <= 1'b1;
                    end
                end
                i2c_switch_pkg::ST_WR_ACK: begin
                    state_reg <= i2c_switch_pkg::ST_WR_DATA;
                    pend_low_reg <= 1'b0;
                end
                i2c_switch_pkg::ST_RD_DATA: begin
                    if (full_reg) begin
                        full_reg <= 1'b0;
                        state_reg <= i2c_switch_pkg::ST_RD_ACK;
                        pend_low_reg <= 1'b0;
                    end else begin
                        tx_reg <= {tx_reg[6:0], 1'b0};
                        pend_low_reg <= !tx_reg[6];
                    end
                end
                i2c_switch_pkg::ST_RD_ACK: begin
                    if (nack_reg) begin
                        state_reg <= i2c_switch_pkg::ST_WAIT_STOP;
                        pend_low_reg <= 1'b0;
                    end else begin
                        state_reg <= i2c_switch_pkg::ST_RD_DATA;
                        tx_reg <= rd_byte;
                        pend_low_reg <= !rd_byte[7];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // sda follows the pending level only after the hold window
    // 75 cycles is 300 ns, well inside the 1 us ack limit
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            hold_cnt_reg <= 7'h0;
            sda_oe_reg <= 1'b0;
        end else if (start_det || stop_det) begin
            hold_cnt_reg <= 7'h0;
            sda_oe_reg <= 1'b0;
        end else if (scl_fall) begin
            hold_cnt_reg <= 7'(i2c_switch_pkg::SDA_HOLD_CYC);
        end else if (hold_cnt_reg != 7'h0) begin
            hold_cnt_reg <= hold_cnt_reg - 7'h1;
            if (hold_cnt_reg == 7'h1) begin
                sda_oe_reg <= pend_low_reg;
            end
        end
    end

    // channels switch only on stop so lines are high on connect
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            chan_reg <= i2c_switch_pkg::CHAN_RST;
        end else if (stop_det) begin
            chan_reg <= {ctrl_reg[i2c_switch_pkg::CTRL_CHAN1_BIT],
                         ctrl_reg[i2c_switch_pkg::CTRL_CHAN0_BIT]};
        end
    end

    // combined interrupt with glitch rejection, bounded well under limits
    // the filter costs about 1 us of latency on assert and 0.5 us on release, traded for spike immunity
    assign irq_any = !(&pins.channel_irq_input);
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            irq_out_reg <= 1'b0;
            irq_cnt_reg <= 10'h0;
        end else if (irq_any == irq_out_reg) begin
            irq_cnt_reg <= 10'h0;
        end else if (irq_any && irq_cnt_reg == 10'(i2c_switch_pkg::IRQ_REJ_L_CYC - 1)) begin
            irq_out_reg <= 1'b1;
            irq_cnt_reg <= 10'h0;
        end else if (!irq_any && irq_cnt_reg == 10'(i2c_switch_pkg::IRQ_REJ_H_CYC - 1)) begin
            irq_out_reg <= 1'b0;
            irq_cnt_reg <= 10'h0;
        end else begin
            irq_cnt_reg <= irq_cnt_reg + 10'h1;
        end
    end

    // status word is a debug view: state, sda drive, interrupt, channels
    always_comb begin
        rd_mux = 32'h0;
        case (AVS_ADDRESS)
            i2c_switch_pkg::OFS_CTRL: rd_mux = {24'h0, rd_byte};
            i2c_switch_pkg::OFS_STATUS: rd_mux = {24'h0, 1'b0, state_reg, sda_oe_reg, irq_out_reg, chan_reg};
            i2c_switch_pkg::OFS_CONFIG: rd_mux = {23'h0, cfg_en_reg, 3'h0, cfg_base_reg};
            default: rd_mux = 32'h0;
        endcase
    end

    // two-wait-state slave: waitrequest drops for one cycle per access
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            wait_reg <= 1'b1;
            rdata_reg <= 32'h0;
        end else if ((AVS_READ || AVS_WRITE) && wait_reg && AVS_WAITREQUEST) begin
            // port wait must still be high, so a request held through its answer is not taken twice
            wait_reg <= 1'b0;
            if (AVS_READ) begin
                rdata_reg <= rd_mux;
            end
        end else begin
            wait_reg <= 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            cfg_base_reg <= i2c_switch_pkg::CFG_BASE_RST;
            cfg_en_reg <= i2c_switch_pkg::CFG_EN_RST;
        // write lands on the edge where the master sees wait low
        end else if (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == i2c_switch_pkg::OFS_CONFIG) begin
            cfg_base_reg <= AVS_WRITEDATA[4:0];
            cfg_en_reg <= AVS_WRITEDATA[i2c_switch_pkg::CFG_EN_BIT];
        end
    end

    // open-drain pins: output level is always low, enable drives
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            SDA_O <= 1'b0;
            SDA_OE <= 1'b0;
            IRQ_O <= 1'b0;
            IRQ_OE <= 1'b0;
            CHAN_ACTIVE <= i2c_switch_pkg::CHAN_RST;
            AVS_READDATA <= 32'h0;
            AVS_WAITREQUEST <= 1'b1;
        end else begin
            SDA_O <= 1'b0;
            SDA_OE <= sda_oe_reg;
            IRQ_O <= 1'b0;
            IRQ_OE <= irq_out_reg;
            CHAN_ACTIVE <= chan_reg;
            AVS_READDATA <= rdata_reg;
            AVS_WAITREQUEST <= wait_reg;
        end
    end
endmodule

// File: testbench/i2c_switch_asserts.sv
// port-level checks for the i2c switch front end
`timescale 1ns/1ns
module i2c_switch_asserts (
    input wire logic CORE_CLK,
    input wire logic RSTN,
    input wire logic SCL_I,
    input wire logic SDA_I,
    input wire logic SDA_O,
    input wire logic SDA_OE,
    input wire logic IRQ_O,
    input wire logic IRQ_OE,
    input wire logic [1:0] CHANNEL_IRQ_INPUT,
    input wire logic [1:0] CHAN_ACTIVE,
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST
);
    logic [9:0] low_cnt_reg;
    logic [10:0] on_cnt_reg;
    logic [10:0] off_cnt_reg;
    logic [7:0] stop_cnt_reg;
    logic sda_q_reg;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);
    // low and stop counters saturate so long idle stretches never wrap into a false pass
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            low_cnt_reg <= 10'h000;
            on_cnt_reg <= 11'h000;
            off_cnt_reg <= 11'h000;
            stop_cnt_reg <= 8'hff;
            sda_q_reg <= 1'b1;
        end else begin
            sda_q_reg <= SDA_I;
            low_cnt_reg <= SCL_I ? 10'h000 : low_cnt_reg + {9'h000, low_cnt_reg != 10'h3ff};
            on_cnt_reg <= (CHANNEL_IRQ_INPUT != 2'b11 && !IRQ_OE) ? on_cnt_reg + 11'h001 : 11'h000;
            off_cnt_reg <= (CHANNEL_IRQ_INPUT == 2'b11 && IRQ_OE) ? off_cnt_reg + 11'h001 : 11'h000;
            stop_cnt_reg <= (SCL_I && !sda_q_reg && SDA_I) ? 8'h00 : stop_cnt_reg + {7'h00, stop_cnt_reg != 8'hff};
        end
    end
    sequence s_answer;
        AVS_WAITREQUEST [*2] ##1 !AVS_WAITREQUEST;
    endsequence
    a_open_drain_lows: assert property (IRQ_O == 1'b0 && SDA_O == 1'b0)
        else $error("open-drain output drives high");
    a_irq_assert_time: assert property (on_cnt_reg < i2c_switch_pkg::IRQ_ASSERT_MAX_CYC)
        else $error("combined interrupt late to assert");
    a_irq_release_time: assert property (off_cnt_reg < i2c_switch_pkg::IRQ_RELEASE_MAX_CYC)
        else $error("combined interrupt late to release");
    a_irq_has_cause: assert property ($rose(IRQ_OE) |-> $past(CHANNEL_IRQ_INPUT) != 2'b11)
        else $error("interrupt asserted with no active input");
    a_sda_hold_time: assert property ((low_cnt_reg != 10'h000 && low_cnt_reg < i2c_switch_pkg::SDA_HOLD_CYC)
        |-> $stable(SDA_OE))
        else $error("sda drive changed inside hold window");
    a_ack_in_time: assert property ($rose(SDA_OE) |-> !SCL_I && low_cnt_reg <= 10'd250)
        else $error("sda pulled low too late after scl fall");
    a_chan_at_stop: assert property ($changed(CHAN_ACTIVE) |-> stop_cnt_reg <= 8'd16)
        else $error("channel selection changed without stop");
    a_reset_clears_all: assert property ($rose(RSTN) |-> CHAN_ACTIVE == 2'b00 && !SDA_OE && !IRQ_OE)
        else $error("outputs not cleared at reset release");
    a_bus_answer_time: assert property ($rose(AVS_READ || AVS_WRITE) |-> s_answer)
        else $error("register bus answer timing wrong");
    a_ctrl_irq_bits: assert property ((AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == i2c_switch_pkg::OFS_CTRL)
        |-> AVS_READDATA[5:4] == ~$past(CHANNEL_IRQ_INPUT, 6))
        else $error("control read shows wrong interrupt levels");
endmodule
bind i2c_switch_slave_front_end i2c_switch_asserts u_chk (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .SCL_I(SCL_I),
    .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE(SDA_OE), .IRQ_O(IRQ_O), .IRQ_OE(IRQ_OE),
    .CHANNEL_IRQ_INPUT(CHANNEL_IRQ_INPUT), .CHAN_ACTIVE(CHAN_ACTIVE), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST));

// File: testbench/i2c_master_model.sv
// upstream i2c bus master model, open drain with pull-ups
`timescale 1ns/1ns
module i2c_master_model #(
    parameter int LOW_CYC = 300,
    parameter int HIGH_CYC = 10
) (
    input wire logic clk,
    input wire logic sda_in,
    output logic scl,
    output logic sda
);
    // low phase stretched: the slave holds its sda drive 300 ns past each fall
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic bit_io(input logic b, output logic r);
        cyc(LOW_CYC / 2);
        sda <= b;
        cyc(LOW_CYC / 2);
        scl <= 1'b1;
        cyc(HIGH_CYC);
        r = sda_in;
        scl <= 1'b0;
    endtask
    task automatic start();
        cyc(HIGH_CYC);
        sda <= 1'b0;
        cyc(HIGH_CYC);
        scl <= 1'b0;
    endtask
    task automatic stop();
        cyc(LOW_CYC / 2);
        sda <= 1'b0;
        cyc(LOW_CYC / 2);
        scl <= 1'b1;
        cyc(HIGH_CYC);
        sda <= 1'b1;
        cyc(330);
    endtask
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    task automatic recv(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(nack, r);
    endtask
endmodule

// File: testbench/tb.sv
// self-checking bench for the i2c switch front end
`timescale 1ns/1ns
`define CHK(n, e, g) begin \
    comparisons++; \
    if ((g) !== (e)) begin \
        failures++; \
        $display("[ERR] %s exp %h got %h", n, e, g); \
    end \
end
module tb;
    logic CORE_CLK = 1'b0;
    logic RSTN = 1'b0;
    logic ADDR_SELECT_LO = 1'b0;
    logic ADDR_SELECT_HI = 1'b1;
    logic [1:0] CHANNEL_IRQ_INPUT = 2'b11;
    logic [3:0] AVS_ADDRESS = 4'h0;
    logic AVS_READ = 1'b0;
    logic AVS_WRITE = 1'b0;
    logic [31:0] AVS_WRITEDATA = 32'h0;
    logic SCL_I, SDA_I, SDA_O, SDA_OE, IRQ_O, IRQ_OE, AVS_WAITREQUEST, m_sda, a;
    logic [1:0] CHAN_ACTIVE;
    logic [31:0] AVS_READDATA, q;
    logic [7:0] b;
    int failures = 0;
    int comparisons = 0;
    always #2 CORE_CLK = ~CORE_CLK;
    assign SDA_I = m_sda & ~SDA_OE;
    i2c_master_model u_master (.clk(CORE_CLK), .sda_in(SDA_I), .scl(SCL_I), .sda(m_sda));
    i2c_switch_slave_front_end i_i2c_switch_slave_front_end (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .SCL_I(SCL_I),
        .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE(SDA_OE), .ADDR_SELECT_LO(ADDR_SELECT_LO),
        .ADDR_SELECT_HI(ADDR_SELECT_HI), .CHANNEL_IRQ_INPUT(CHANNEL_IRQ_INPUT), .IRQ_O(IRQ_O), .IRQ_OE(IRQ_OE),
        .CHAN_ACTIVE(CHAN_ACTIVE), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
        .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST));
    task automatic stop_test();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic av(input logic wr, input logic [3:0] ad, input logic [31:0] d, output logic [31:0] rd);
        int n;
        @(posedge CORE_CLK);
        AVS_ADDRESS <= ad;
        AVS_WRITEDATA <= d;
        AVS_READ <= ~wr;
        AVS_WRITE <= wr;
        n = 0;
        do begin
            @(posedge CORE_CLK);
            n++;
        end while (AVS_WAITREQUEST !== 1'b0 && n < 50);
        rd = AVS_READDATA;
        AVS_READ <= 1'b0;
        AVS_WRITE <= 1'b0;
        if (n >= 50) begin
            failures++;
            stop_test();
        end
    endtask
    task automatic wait_irq(input logic v, input int lim);
        int n;
        n = 0;
        while (IRQ_OE !== v && n < lim) begin
            @(posedge CORE_CLK);
            n++;
        end
        if (IRQ_OE !== v) begin
            failures++;
            stop_test();
        end
    endtask
    task automatic t_write();
        u_master.start();
        u_master.send(8'h74, a);
        `CHK("addr ack", 1'b1, a)
        u_master.send(8'h02, a);
        u_master.send(8'h31, a);
        `CHK("data ack", 1'b1, a)
        `CHK("chan before stop", 2'b00, CHAN_ACTIVE)
        u_master.stop();
        `CHK("chan after stop", 2'b01, CHAN_ACTIVE)
        av(1'b1, i2c_switch_pkg::OFS_CTRL, 32'h3, q);
        av(1'b0, i2c_switch_pkg::OFS_CTRL, 32'h0, q);
        `CHK("ctrl read", 32'h00000001, q)
        av(1'b0, i2c_switch_pkg::OFS_STATUS, 32'h0, q);
        `CHK("status idle", 32'h00000001, q)
        $display("test write done");
    endtask
    task automatic t_read();
        @(posedge CORE_CLK);
        CHANNEL_IRQ_INPUT <= 2'b10;
        repeat (300) @(posedge CORE_CLK);
        u_master.start();
        u_master.send(8'h75, a);
        `CHK("read addr ack", 1'b1, a)
        u_master.recv(1'b1, b);
        `CHK("read byte", 8'h11, b)
        u_master.stop();
        av(1'b0, i2c_switch_pkg::OFS_CTRL, 32'h0, q);
        `CHK("ctrl irq bits", 32'h00000011, q)
        @(posedge CORE_CLK);
        CHANNEL_IRQ_INPUT <= 2'b11;
        wait_irq(1'b0, i2c_switch_pkg::IRQ_RELEASE_MAX_CYC);
        `CHK("irq off after read", 1'b0, IRQ_OE)
        $display("test read done");
    endtask
    task automatic t_irq();
        for (int c = 0; c < 2; c++) begin
            @(posedge CORE_CLK);
            CHANNEL_IRQ_INPUT <= c ? 2'b01 : 2'b10;
            wait_irq(1'b1, i2c_switch_pkg::IRQ_ASSERT_MAX_CYC);
            `CHK("irq on", 1'b1, IRQ_OE)
            `CHK("irq level", 1'b0, IRQ_O)
            @(posedge CORE_CLK);
            CHANNEL_IRQ_INPUT <= 2'b11;
            wait_irq(1'b0, i2c_switch_pkg::IRQ_RELEASE_MAX_CYC);
            `CHK("irq off", 1'b0, IRQ_OE)
        end
        $display("test irq done");
    endtask
    task automatic t_refuse();
        av(1'b0, i2c_switch_pkg::OFS_CONFIG, 32'h0, q);
        `CHK("config reset", 32'h0000010e, q)
        av(1'b0, 4'hc, 32'h0, q);
        `CHK("unmapped read", 32'h0, q)
        u_master.start();
        u_master.send(8'h76, a);
        `CHK("wrong addr nack", 1'b0, a)
        u_master.stop();
        av(1'b1, i2c_switch_pkg::OFS_CONFIG, 32'h0000000e, q);
        u_master.start();
        u_master.send(8'h74, a);
        `CHK("disabled nack", 1'b0, a)
        u_master.stop();
        av(1'b1, i2c_switch_pkg::OFS_CONFIG, 32'h0000010e, q);
        $display("test refuse done");
    endtask
    task automatic t_reset_mid();
        @(posedge CORE_CLK);
        RSTN <= 1'b0;
        repeat (2) @(posedge CORE_CLK);
        RSTN <= 1'b1;
        @(posedge CORE_CLK);
        `CHK("chan cleared", 2'b00, CHAN_ACTIVE)
        `CHK("wait idle", 1'b1, AVS_WAITREQUEST)
        av(1'b0, i2c_switch_pkg::OFS_CTRL, 32'h0, q);
        `CHK("ctrl cleared", 32'h00000000, q)
        u_master.start();
        u_master.send(8'h74, a);
        `CHK("ack after reset", 1'b1, a)
        u_master.send(8'h02, a);
        u_master.stop();
        `CHK("chan one", 2'b10, CHAN_ACTIVE)
        $display("test reset done");
    endtask
    initial begin
        repeat (8) @(posedge CORE_CLK);
        RSTN <= 1'b1;
        t_write();
        t_read();
        t_irq();
        t_refuse();
        t_reset_mid();
        stop_test();
    end
endmodule
